// ===== src/atc_pkg.sv
// Purpose: shared constants, carriers and helpers of the threshold comparator
// Assumes: one 25 MHz clock; operands are unsigned and arrive already converted
// Notes:   all arithmetic is 32-bit; signed except the unsigned display wrap
package atc_pkg;

  // timing
  localparam int clk_period_ns  = 40;
  localparam int scan_period_ns = 10000;
  localparam int scan_cycles    = scan_period_ns / clk_period_ns;

  // widths
  localparam int param_w  = 14;
  localparam int code_w   = 10;
  localparam int actual_w = 16;
  localparam int val_w    = 32;

  // limits
  localparam logic [13:0] param_max    = 14'h270F;
  localparam logic [9:0]  code_max     = 10'h3FF;
  localparam logic [31:0] display_max  = 32'h0000_270F;
  localparam logic [31:0] display_wrap = 32'h0000_2710;
  localparam logic [13:0] gain_unset   = 14'h0000;

  // compare modes
  localparam logic [2:0] mode_less             = 3'h0;
  localparam logic [2:0] mode_less_or_equal    = 3'h1;
  localparam logic [2:0] mode_equal            = 3'h2;
  localparam logic [2:0] mode_greater_or_equal = 3'h3;
  localparam logic [2:0] mode_greater          = 3'h4;

  // operand sources
  localparam logic [1:0] src_analog = 2'h0;
  localparam logic [1:0] src_fixed  = 2'h1;
  localparam logic [1:0] src_actual = 2'h2;

  typedef struct packed {
    logic [2:0]  mode;
    logic [13:0] first_gain;
    logic [13:0] second_gain;
    logic [13:0] first_offset;
    logic [13:0] switch_hysteresis;
  } atc_param_type;

  typedef struct packed {
    logic [1:0]  sel;
    logic [9:0]  analog;
    logic [13:0] fixed;
    logic [15:0] actual;
  } atc_operand_type;

  typedef enum logic [1:0] {ph_idle, ph_scale, ph_decide} atc_phase_type;

  // picks the operand from its source, zero extended
  function automatic logic signed [31:0] atc_raw(atc_operand_type op);
    logic signed [31:0] r;
    r = '0;
    if (op.sel == src_analog)
      r = {22'h000000, op.analog};
    else if (op.sel == src_fixed)
      r = {18'h00000, op.fixed};
    else
      r = {16'h0000, op.actual};
    return r;
  endfunction

  // four-digit display: values above the limit show minus the wrap
  function automatic logic [31:0] atc_display(logic signed [31:0] v);
    logic [31:0] d;
    d = v;
    if (d > display_max)
      d = d - display_wrap;
    return d;
  endfunction

endpackage

// ===== src/atc_scaler.sv
// Purpose: gain stage, one operand times its gain at full precision
// Assumes: operand and gain are non-negative
// Notes:   result registered one cycle after the load pulse
`timescale 1ns/100ps
module atc_scaler
  import atc_pkg::*;
(
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  // request
  input  wire logic               i_load,
  input  wire logic signed [31:0] i_raw,
  input  wire logic [13:0]        i_gain,
  // result
  output logic signed [31:0]      o_scaled,
  output logic                    o_valid
);

  logic               gain_set;
  logic signed [31:0] product;
  logic signed [31:0] next_scaled;

  assign gain_set    = (i_gain != gain_unset);
  assign product     = i_raw * $signed({18'h00000, i_gain});
  assign next_scaled = gain_set ? product : i_raw;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_scaled <= '0;
      o_valid  <= 1'b0;
    end else begin
      o_valid <= i_load;
      if (i_load)
        o_scaled <= next_scaled;
    end
  end

  property p_unset_gain_passes;
    @(posedge i_clk) disable iff (i_rst)
    i_load && (i_gain == gain_unset) |=> o_scaled == $past(i_raw);
  endproperty
  a_unset_gain_passes: assert property (p_unset_gain_passes)
    else $error("unset gain did not pass the raw operand");

  property p_full_product;
    @(posedge i_clk) disable iff (i_rst)
    i_load && (i_gain != gain_unset) |=>
      o_valid && o_scaled == $past(i_raw) * $signed({18'h00000,
                                                     $past(i_gain)});
  endproperty
  a_full_product: assert property (p_full_product)
    else $error("gain product not at full precision");

  property p_no_overflow;
    @(posedge i_clk) disable iff (i_rst)
    o_valid |-> o_scaled >= $past(i_raw);
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("scaled operand overflowed");

endmodule

// ===== src/atc_comparator.sv
// Purpose: threshold comparator driving one boolean contact
// Assumes: parameter and operand ports steady or sampled once per scan
// Notes:   decision lands three clocks after each scan tick
`timescale 1ns/100ps
// Overview of operation
// - all gain and compare arithmetic is signed 32-bit, so nothing overflows.
// - each gain product is formed at full precision before comparing.
// - a zero gain means the raw operand is used unmultiplied.
// - operand values above 9999 are displayed minus 10000; compare uses full.
// - analog operands are unsigned 10-bit codes from 0 to 1023.
// - inclusive modes switch on at equality; strict modes do not.
// - less mode turns the contact on below the setpoint.
// - less-or-equal turns the contact on at or below the setpoint.
// - less modes turn off only above setpoint plus hysteresis.
// - equal mode on at setpoint, off below setpoint minus hysteresis.
// - equal mode also turns off above the setpoint.
// - greater-or-equal on at setpoint, off below setpoint minus hysteresis.
// - greater on past setpoint, off below setpoint minus hysteresis.
// - one hysteresis value serves as both upper and lower margin.
// - the first operand is its gain-scaled value plus the offset.
// - gain, offset and hysteresis are accepted only from 0 to 9999.
// - exactly five compare modes are selectable.
module atc_comparator
  import atc_pkg::*;
#(
  parameter int SCAN_CYCLES = scan_cycles
)
(
  // clock and reset
  input  wire logic            I_CLK,
  input  wire logic            I_RST,
  // configuration
  input  wire atc_param_type   I_PARAM,
  // operands
  input  wire atc_operand_type I_FIRST_OPERAND,
  input  wire atc_operand_type I_SECOND_OPERAND_SETPOINT,
  // contact and status
  output logic                 O_COMPARATOR_INSTANCE_OUTPUT,
  output logic                 O_PARAM_ERROR,
  output logic                 O_SCAN_DONE,
  // display values
  output logic [31:0]          O_FIRST_DISPLAY,
  output logic [31:0]          O_SECOND_DISPLAY
);

  localparam int cnt_w = $clog2(SCAN_CYCLES + 1);
  localparam logic [cnt_w-1:0] cnt_last = cnt_w'(SCAN_CYCLES - 1);

  logic [cnt_w-1:0]   div_cnt;
  logic               scan_tick;
  atc_phase_type      phase;
  atc_param_type      par;
  logic signed [31:0] raw_first;
  logic signed [31:0] raw_second;
  logic signed [31:0] scaled_first;
  logic signed [31:0] scaled_second;
  logic               first_valid;
  logic               second_valid;
  logic               contact;

  // scan divider
  assign scan_tick = (div_cnt == cnt_last);

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST)
      div_cnt <= '0;
    else if (scan_tick)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 1'b1;
  end

  // parameter acceptance
  logic param_ok;
  logic mode_ok;
  logic take_scan;

  assign mode_ok   = (I_PARAM.mode <= mode_greater);
  assign param_ok  = mode_ok
                   && (I_PARAM.first_gain <= param_max)
                   && (I_PARAM.second_gain <= param_max)
                   && (I_PARAM.first_offset <= param_max)
                   && (I_PARAM.switch_hysteresis <= param_max);
  assign take_scan = scan_tick && (phase == ph_idle);

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      par           <= '0;
      O_PARAM_ERROR <= 1'b0;
    end else if (take_scan) begin
      O_PARAM_ERROR <= !param_ok;
      if (param_ok)
        par <= I_PARAM;
    end
  end

  // operand capture and display
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      raw_first        <= '0;
      raw_second       <= '0;
      O_FIRST_DISPLAY  <= '0;
      O_SECOND_DISPLAY <= '0;
    end else if (take_scan) begin
      raw_first        <= atc_raw(I_FIRST_OPERAND);
      raw_second       <= atc_raw(I_SECOND_OPERAND_SETPOINT);
      O_FIRST_DISPLAY  <= atc_display(atc_raw(I_FIRST_OPERAND));
      O_SECOND_DISPLAY <= atc_display(atc_raw(I_SECOND_OPERAND_SETPOINT));
    end
  end

  // gain stages
  logic load_scale;

  assign load_scale = (phase == ph_scale);

  atc_scaler u_scale_first (
    .i_clk    (I_CLK),
    .i_rst    (I_RST),
    .i_load   (load_scale),
    .i_raw    (raw_first),
    .i_gain   (par.first_gain),
    .o_scaled (scaled_first),
    .o_valid  (first_valid)
  );

  atc_scaler u_scale_second (
    .i_clk    (I_CLK),
    .i_rst    (I_RST),
    .i_load   (load_scale),
    .i_raw    (raw_second),
    .i_gain   (par.second_gain),
    .o_scaled (scaled_second),
    .o_valid  (second_valid)
  );

  // comparison, all in 32-bit signed
  logic signed [31:0] first_value;
  logic signed [31:0] setpoint;
  logic signed [31:0] hyst;
  logic signed [31:0] upper;
  logic signed [31:0] lower;
  logic               is_lt;
  logic               is_eq;
  logic               is_gt;
  logic               above_band;
  logic               below_band;
  logic               less_mode;
  logic               on_cond;
  logic               off_cond;
  logic               decide;
  logic               next_contact;

  assign first_value = scaled_first
                     + $signed({18'h00000, par.first_offset});
  assign setpoint    = scaled_second;
  assign hyst        = $signed({18'h00000, par.switch_hysteresis});
  assign upper       = setpoint + hyst;
  assign lower       = setpoint - hyst;
  assign is_lt       = first_value < setpoint;
  assign is_eq       = first_value == setpoint;
  assign is_gt       = first_value > setpoint;
  assign above_band  = first_value > upper;
  assign below_band  = first_value < lower;
  assign less_mode   = (par.mode == mode_less)
                     || (par.mode == mode_less_or_equal);

  assign on_cond =
    (par.mode == mode_less)             ? is_lt :
    (par.mode == mode_less_or_equal)    ? (is_lt || is_eq) :
    (par.mode == mode_equal)            ? is_eq :
    (par.mode == mode_greater_or_equal) ? (is_gt || is_eq) :
                                          is_gt;
  assign off_cond =
    less_mode                ? above_band :
    (par.mode == mode_equal) ? (below_band || is_gt) :
                               below_band;

  assign decide       = (phase == ph_decide) && first_valid && second_valid;
  assign next_contact = on_cond  ? 1'b1 :
                        off_cond ? 1'b0 :
                                   contact;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST)
      phase <= ph_idle;
    else begin
      case (phase)
        ph_idle:   if (take_scan) phase <= ph_scale;
        ph_scale:  phase <= ph_decide;
        ph_decide: if (decide) phase <= ph_idle;
        default:   phase <= ph_idle;
      endcase
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      contact     <= 1'b0;
      O_SCAN_DONE <= 1'b0;
    end else begin
      O_SCAN_DONE <= decide;
      if (decide)
        contact <= next_contact;
    end
  end

  assign O_COMPARATOR_INSTANCE_OUTPUT = contact;

  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  property p_less_on;
    decide && par.mode == mode_less && is_lt |=> contact;
  endproperty
  a_less_on: assert property (p_less_on)
    else $error("less mode did not switch on below setpoint");

  property p_le_on;
    decide && par.mode == mode_less_or_equal && is_eq |=> contact;
  endproperty
  a_le_on: assert property (p_le_on)
    else $error("less-or-equal did not switch on at setpoint");

  property p_less_off;
    decide && less_mode && first_value > setpoint + hyst |=> !contact;
  endproperty
  a_less_off: assert property (p_less_off)
    else $error("less mode did not switch off above band");

  property p_less_hold;
    decide && less_mode && !is_lt && !is_eq && !above_band
      |=> contact == $past(contact);
  endproperty
  a_less_hold: assert property (p_less_hold)
    else $error("less mode changed contact inside band");

  property p_eq_on;
    decide && par.mode == mode_equal && is_eq |=> contact;
  endproperty
  a_eq_on: assert property (p_eq_on)
    else $error("equal mode did not switch on at setpoint");

  property p_eq_above_off;
    decide && par.mode == mode_equal && is_gt |=> !contact;
  endproperty
  a_eq_above_off: assert property (p_eq_above_off)
    else $error("equal mode stayed on above setpoint");

  property p_ge_on;
    decide && par.mode == mode_greater_or_equal && is_eq |=> contact;
  endproperty
  a_ge_on: assert property (p_ge_on)
    else $error("greater-or-equal did not switch on at setpoint");

  property p_gt_equal_holds;
    decide && par.mode == mode_greater && is_eq
      |=> contact == $past(contact);
  endproperty
  a_gt_equal_holds: assert property (p_gt_equal_holds)
    else $error("strict greater switched at equality");

  property p_gt_off;
    decide && par.mode >= mode_greater_or_equal
      && first_value < setpoint - hyst |=> !contact;
  endproperty
  a_gt_off: assert property (p_gt_off)
    else $error("greater mode did not switch off below band");

  property p_param_reject;
    take_scan && !param_ok |=> O_PARAM_ERROR && par == $past(par);
  endproperty
  a_param_reject: assert property (p_param_reject)
    else $error("out of range parameter was taken");

  property p_param_take;
    take_scan && param_ok |=> !O_PARAM_ERROR && par == $past(I_PARAM);
  endproperty
  a_param_take: assert property (p_param_take)
    else $error("in range parameter set was not taken");

  property p_scan_latency;
    take_scan |-> ##3 O_SCAN_DONE;
  endproperty
  a_scan_latency: assert property (p_scan_latency)
    else $error("scan did not complete in three clocks");

  property p_display_wrap;
    take_scan && I_FIRST_OPERAND.sel == src_actual
      && I_FIRST_OPERAND.actual > 16'h270F
      |=> O_FIRST_DISPLAY
          == 32'($past(I_FIRST_OPERAND.actual)) - display_wrap;
  endproperty
  a_display_wrap: assert property (p_display_wrap)
    else $error("display not reduced above four digits");

  c_less_on: cover property (decide && par.mode == mode_less && on_cond
                             && !contact);
  c_eq_above: cover property (decide && par.mode == mode_equal && is_gt
                              && contact);
  c_band_hold: cover property (decide && !on_cond && !off_cond);
  c_reject: cover property (take_scan && !param_ok);
  c_gt_equal: cover property (decide && par.mode == mode_greater && is_eq);

endmodule

// ===== tb/atc_source_model.sv
// Purpose: operand source standing in for the converter and value sources
// Assumes: selected field follows the request; analog saturates at 1023
// Notes:   unselected fields carry a pattern that changes every clock
`timescale 1ns/100ps
module atc_source_model
  import atc_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // requested source and value
  input  wire logic [1:0]  i_sel,
  input  wire logic [15:0] i_value,
  // operand toward the comparator
  output atc_operand_type  o_op
);
  logic [15:0] noise;
  logic [9:0]  code;
  logic        use_analog;
  logic        use_fixed;

  // converter code never exceeds full scale
  assign code       = (i_value > 16'(code_max)) ? code_max : i_value[9:0];
  assign use_analog = (i_sel == src_analog);
  assign use_fixed  = (i_sel == src_fixed);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst)
      noise <= 16'hA5C3;
    else
      noise <= ~{noise[14:0], noise[15]};
  end

  assign o_op = '{sel:    i_sel,
                  analog: use_analog ? code : noise[9:0],
                  fixed:  use_fixed ? i_value[13:0] : noise[13:0],
                  actual: (!use_analog && !use_fixed) ? i_value : noise};
endmodule

// ===== tb/analog_threshold_comparator_bench.sv
// Purpose: self-checking bench for the threshold comparator
// Assumes: scan shortened to 8 clocks; operands from two source models
// Notes:   rows run in order, so each expected contact includes history
`timescale 1ns/100ps
module analog_threshold_comparator_bench
  import atc_pkg::*;
;
  localparam int scan = 8;
  typedef struct packed {
    logic [2:0]  mode;
    logic [13:0] g1;
    logic [13:0] g2;
    logic [13:0] os;
    logic [13:0] hy;
    logic [1:0]  s1;
    logic [15:0] v1;
    logic [1:0]  s2;
    logic [15:0] v2;
    logic        c;
    logic        e;
  } atc_row_type;
  logic            clk;
  logic            rst;
  atc_param_type   param;
  logic [1:0]      sel1;
  logic [15:0]     val1;
  logic [1:0]      sel2;
  logic [15:0]     val2;
  atc_operand_type op1;
  atc_operand_type op2;
  logic            contact;
  logic            perr;
  logic            done;
  logic [31:0]     disp1;
  logic [31:0]     disp2;
  atc_row_type     rows [0:28];
  atc_row_type     r;
  int              errors;
  int              compares;
  int              i;

  atc_source_model src1 (
    .i_clk   (clk),
    .i_rst   (rst),
    .i_sel   (sel1),
    .i_value (val1),
    .o_op    (op1)
  );
  atc_source_model src2 (
    .i_clk   (clk),
    .i_rst   (rst),
    .i_sel   (sel2),
    .i_value (val2),
    .o_op    (op2)
  );
  atc_comparator #(.SCAN_CYCLES(scan)) uut (
    .I_CLK                        (clk),
    .I_RST                        (rst),
    .I_PARAM                      (param),
    .I_FIRST_OPERAND              (op1),
    .I_SECOND_OPERAND_SETPOINT    (op2),
    .O_COMPARATOR_INSTANCE_OUTPUT (contact),
    .O_PARAM_ERROR                (perr),
    .O_SCAN_DONE                  (done),
    .O_FIRST_DISPLAY              (disp1),
    .O_SECOND_DISPLAY             (disp2)
  );

  always #20 clk = ~clk;

  function automatic logic [31:0] disp(logic [15:0] v);
    return (v > 16'h270F) ? 32'(v) - 32'h2710 : 32'(v);
  endfunction

  task automatic check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // waits for the end of the next scan, sampled away from the edge
  task automatic wait_done;
    int n;
    n = 0;
    @(negedge clk);
    while (done !== 1'b1 && n < 4 * scan) begin
      @(negedge clk);
      n++;
    end
    if (done !== 1'b1) begin
      errors++;
      conclude();
    end
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    param = '0;
    sel1 = '0;
    val1 = '0;
    sel2 = '0;
    val2 = '0;
    errors = 0;
    compares = 0;
    // mode, gains, offset, hysteresis (20 or more), sources, contact, error
    rows = '{
      '{0, 0, 0, 0, 25, 1, 100, 1, 100, 0, 0},
      '{0, 0, 0, 0, 25, 1, 99, 1, 100, 1, 0},
      '{0, 0, 0, 0, 25, 1, 125, 1, 100, 1, 0},
      '{0, 0, 0, 0, 25, 1, 126, 1, 100, 0, 0},
      '{1, 0, 0, 0, 25, 1, 100, 1, 100, 1, 0},
      '{1, 0, 0, 0, 25, 1, 126, 1, 100, 0, 0},
      '{2, 0, 0, 0, 25, 1, 100, 1, 100, 1, 0},
      '{2, 0, 0, 0, 25, 1, 76, 1, 100, 1, 0},
      '{2, 0, 0, 0, 25, 1, 74, 1, 100, 0, 0},
      '{2, 0, 0, 0, 25, 1, 100, 1, 100, 1, 0},
      '{2, 0, 0, 0, 25, 1, 101, 1, 100, 0, 0},
      '{3, 0, 0, 0, 25, 1, 100, 1, 100, 1, 0},
      '{3, 0, 0, 0, 25, 1, 75, 1, 100, 1, 0},
      '{3, 0, 0, 0, 25, 1, 74, 1, 100, 0, 0},
      '{4, 0, 0, 0, 25, 1, 100, 1, 100, 0, 0},
      '{4, 0, 0, 0, 25, 1, 101, 1, 100, 1, 0},
      '{4, 0, 0, 0, 25, 1, 75, 1, 100, 1, 0},
      '{4, 0, 0, 0, 25, 1, 74, 1, 100, 0, 0},
      '{2, 10, 0, 0, 250, 0, 300, 1, 3000, 1, 0},
      '{2, 10, 0, 0, 250, 0, 200, 1, 3000, 0, 0},
      '{4, 9999, 9999, 0, 25, 2, 9999, 1, 9999, 0, 0},
      '{4, 9999, 9999, 1, 25, 2, 9999, 1, 9999, 1, 0},
      '{3, 0, 0, 0, 25, 1, 0, 1, 50, 0, 0},
      '{3, 0, 0, 0, 25, 1, 50, 1, 50, 1, 0},
      '{0, 0, 0, 0, 25, 2, 10233, 2, 10300, 1, 0},
      '{0, 0, 0, 0, 10000, 1, 200, 1, 100, 0, 1},
      '{5, 0, 0, 0, 25, 1, 50, 1, 100, 1, 1},
      '{4, 0, 0, 0, 25, 1, 50, 1, 100, 0, 0},
      '{3, 0, 0, 0, 25, 0, 1023, 1, 1023, 1, 0}
    };
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check_bit(contact, 1'b0);
    check_bit(perr, 1'b0);
    check_bit(done, 1'b0);
    for (i = 0; i < 29; i++) begin
      r = rows[i];
      @(posedge clk);
      param <= '{r.mode, r.g1, r.g2, r.os, r.hy};
      sel1 <= r.s1;
      val1 <= r.v1;
      sel2 <= r.s2;
      val2 <= r.v2;
      wait_done();
      check_bit(contact, r.c);
      check_bit(perr, r.e);
      check_word(disp1, disp(r.v1));
      check_word(disp2, disp(r.v2));
      @(negedge clk);
      check_bit(done, 1'b0);
    end
    // reset in mid-run clears the contact, then the next scan restores it
    @(posedge clk);
    rst <= 1'b1;
    @(negedge clk);
    check_bit(contact, 1'b0);
    check_bit(perr, 1'b0);
    check_word(disp1, 32'h0000_0000);
    @(posedge clk);
    rst <= 1'b0;
    wait_done();
    check_bit(contact, 1'b1);
    check_word(disp1, 32'h0000_03FF);
    conclude();
  end
endmodule
